// *** hdl/dif_frontend.sv ***
// Distributor interface front end: register port, stream links, credits
// How it works
// - Each link holds one single-beat packet; order kept, never interleaved.
// - Inbound translation messages limited to base credits plus locked credits.
// - Cross-chip message transfers capped by their own token pool.
// - Soft and virtual soft interrupts across chips each have a token pool.
// - Stream links carry no parity signals.
// - Inbound translation link is 16 bits and reports sender number.
// - Chip link destination is programmed; wake link has no destination.
// - Stream wake lines come from registered valid, never from logic.
// - Register port reaches all registers, message translation register included (MONOLITHIC build).
// - Only single-beat accesses matching register size are accepted.
// - Shared port: translation device id taken from write-user bits.
// - One access at a time, within the 3/2/2 limits, in order.
// - Only protection bit 1 matters; it selects non-secure access.
// - Size comes from strobes; non-contiguous or misaligned runs are rejected.
// - Register-port wake input forces the distributor awake.
// - Undefined accesses are ignored but still completed legally.
// - Errant accesses logged in record 0; slave error only when enabled.
// - Disable bits suppress reporting of chosen error types.
// - ECC corruption: nothing, slave error, or read poison by controls.
// - Write-poison mode chooses reject-and-report or ignore poison.
// - No decode error is ever returned; no dataless stash expected.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
module dif_frontend (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register port
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [dif_pkg::AW-1:0] paddr,
	input wire logic [dif_pkg::DW-1:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [2:0] pprot,
	input wire logic [dif_pkg::DID_W-1:0] pwuser,
	input wire logic wr_poison,
	input wire logic pwakeup,
	output logic [dif_pkg::DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic rd_poison,
	// Interrupt state read path
	input wire logic [dif_pkg::DW-1:0] istate_data,
	input wire logic istate_ecc_err,
	// Inbound translation link
	input wire logic xlat_tvalid,
	input wire logic [15:0] xlat_tdata,
	input wire logic [dif_pkg::SRC_W-1:0] xlat_tid,
	input wire logic xlat_twakeup,
	output logic xlat_tready,
	output logic xlat_credit_ret,
	// Inbound messages to core logic
	output logic in_valid,
	output logic [15:0] in_data,
	output logic [dif_pkg::SRC_W-1:0] in_src,
	input wire logic in_done,
	// Outbound cross-chip link
	input wire logic msg_valid,
	input wire logic [1:0] msg_class,
	input wire logic [63:0] msg_data,
	output logic msg_ack,
	output logic chip_tvalid,
	output logic [63:0] chip_tdata,
	output logic [dif_pkg::DEST_W-1:0] chip_tdest,
	output logic [1:0] chip_tuser,
	output logic chip_twakeup,
	input wire logic chip_tready,
	input wire logic [2:0] chip_credit_ret,
	// Outbound wake link
	input wire logic wk_valid,
	input wire logic [15:0] wk_data,
	output logic wk_ack,
	output logic wake_tvalid,
	output logic [15:0] wake_tdata,
	output logic wake_twakeup,
	input wire logic wake_tready,
	// Misc
	output logic qactive,
	output logic xlat_req,
	output logic [dif_pkg::DID_W-1:0] xlat_did
);
	import dif_pkg::*;

	typedef struct packed {
		dif_apb_t apb_st;
		dif_err_t cur_err;
		logic pready;
		logic pslverr;
		logic rd_poison;
		logic [DW-1:0] prdata;
		logic ue;
		logic [NDIS-1:0] dis;
		logic rp;
		logic wp;
		logic err_v;
		dif_err_t err_type;
		logic [AW-1:0] err_addr;
		logic [DEST_W-1:0] chip_dest;
		logic [DID_W-1:0] xlat_did;
		logic xlat_req;
		logic in_valid;
		logic [15:0] in_data;
		logic [SRC_W-1:0] in_src;
		logic xlat_tready;
		logic xlat_credit_ret;
		logic msg_ack;
		logic chip_tvalid;
		logic [63:0] chip_tdata;
		logic [DEST_W-1:0] chip_tdest;
		logic [1:0] chip_tuser;
		logic chip_twakeup;
		logic wk_ack;
		logic wake_tvalid;
		logic [15:0] wake_tdata;
		logic wake_twakeup;
		logic qactive;
	} dif_st_t;

	dif_st_t s_q;
	dif_st_t s_d;
	logic [NPOOL-1:0] take_v;
	logic [NPOOL-1:0] give_v;
	logic [NPOOL-1:0] avail_v;
	logic [NPOOL-1:0][CW-1:0] count_v;

	dif_credit_if cr[NPOOL]();

	genvar g;
	generate
		for (g = 0; g < NPOOL; g++) begin : g_pool
			assign cr[g].take = take_v[g];
			assign cr[g].give = give_v[g];
			assign cr[g].limit = POOL_LIMIT[g];
			assign avail_v[g] = cr[g].avail;
			assign count_v[g] = cr[g].count;
			dif_credit u_credit (
				.core_clk(core_clk),
				.rst_n(rst_n),
				.cr(cr[g])
			);
		end
	endgenerate

	// Bytes named by a strobe pattern; zero for a broken or misaligned run
	function automatic logic [2:0] strb_bytes(input logic [3:0] s);
		logic [2:0] n;
		case (s)
			4'h1, 4'h2, 4'h4, 4'h8: n = 3'h1;
			4'h3, 4'hc: n = 3'h2;
			4'hf: n = 3'h4;
			default: n = 3'h0;
		endcase
		return n;
	endfunction : strb_bytes

	function automatic logic report_ok(input dif_err_t e, input logic [NDIS-1:0] d,
		input logic rp);
		logic r;
		case (e)
			ERR_RANGE: r = !d[DIS_RANGE];
			ERR_UNIMP: r = !d[DIS_UNIMP];
			ERR_SIZE: r = !d[DIS_SIZE];
			ERR_POISON: r = 1'b1;
			ERR_ECC: r = !rp;
			default: r = 1'b0;
		endcase
		return r;
	endfunction : report_ok

	always_comb begin
		dif_err_t err;
		logic known;
		logic sec_reg;
		logic ns_block;
		logic [DW-1:0] rd;
		logic [1:0] mp;
		logic [CW-1:0] nxt;
		s_d = s_q;
		err = ERR_NONE;
		known = 1'b1;
		sec_reg = 1'b0;
		ns_block = 1'b0;
		rd = '0;
		take_v = '0;
		give_v = '0;
		mp = msg_class + 2'h1;
		nxt = '0;
		s_d.xlat_req = 1'b0;
		case (paddr)
			OFF_ERR_CTRL: begin
				sec_reg = 1'b1;
				rd[UE_BIT] = s_q.ue;
				rd[DIS_LSB +: NDIS] = s_q.dis;
			end
			OFF_FUNC_CTRL: begin
				sec_reg = 1'b1;
				rd[RP_BIT] = s_q.rp;
				rd[WP_BIT] = s_q.wp;
			end
			OFF_ERR_STAT: begin
				sec_reg = 1'b1;
				rd[ERRV_BIT] = s_q.err_v;
				rd[ETYPE_LSB +: 3] = s_q.err_type;
			end
			OFF_ERR_ADDR: begin
				sec_reg = 1'b1;
				rd[AW-1:0] = s_q.err_addr;
			end
			OFF_CHIP_DEST: rd[DEST_W-1:0] = s_q.chip_dest;
			OFF_LINK_STAT: rd[NPOOL*CW-1:0] = count_v;
			OFF_XLAT_DID: rd[DID_W-1:0] = s_q.xlat_did;
			OFF_ISTATE: rd = istate_data;
			OFF_MSG_XLAT: known = MONOLITHIC;
			default: known = 1'b0;
		endcase
		// Non-secure view of secure registers reads zero, writes dropped
		ns_block = sec_reg && pprot[PROT_NS_BIT];
		if (ns_block) begin
			rd = '0;
		end
		if (!known) begin
			err = (paddr >= UNIMP_BASE) ? ERR_UNIMP : ERR_RANGE;
		end else if (pwrite && strb_bytes(pstrb) != REG_BYTES) begin
			err = ERR_SIZE;
		end else if (pwrite && s_q.wp && wr_poison) begin
			err = ERR_POISON;
		end else if (!pwrite && paddr == OFF_ISTATE && istate_ecc_err) begin
			err = ERR_ECC;
		end
		// One wait state, then one commit edge; one access at a time
		case (s_q.apb_st)
			APB_IDLE: begin
				if (psel && penable) begin
					s_d.apb_st = APB_DONE;
					s_d.pready = 1'b1;
					s_d.cur_err = err;
					s_d.prdata = (pwrite || (err != ERR_NONE && err != ERR_ECC)) ? '0 : rd;
					s_d.rd_poison = !pwrite && err == ERR_ECC && s_q.rp;
					s_d.pslverr = s_q.ue && report_ok(err, s_q.dis, s_q.rp);
				end
			end
			APB_DONE: begin
				s_d.apb_st = APB_IDLE;
				s_d.pready = 1'b0;
				s_d.pslverr = 1'b0;
				s_d.rd_poison = 1'b0;
				s_d.prdata = '0;
				if (psel && penable) begin
					if (s_q.cur_err != ERR_NONE) begin
						s_d.err_v = 1'b1;
						s_d.err_type = s_q.cur_err;
						s_d.err_addr = paddr;
					end else if (pwrite && !ns_block) begin
						case (paddr)
							OFF_ERR_CTRL: begin
								s_d.ue = pwdata[UE_BIT];
								s_d.dis = pwdata[DIS_LSB +: NDIS];
							end
							OFF_FUNC_CTRL: begin
								s_d.rp = pwdata[RP_BIT];
								s_d.wp = pwdata[WP_BIT];
							end
							OFF_ERR_STAT: begin
								if (pwdata[ERRV_BIT]) begin
									s_d.err_v = 1'b0;
								end
							end
							OFF_CHIP_DEST: s_d.chip_dest = pwdata[DEST_W-1:0];
							OFF_MSG_XLAT: begin
								s_d.xlat_did = pwuser;
								s_d.xlat_req = 1'b1;
							end
							default: ;
						endcase
					end
				end
			end
			default: s_d.apb_st = APB_IDLE;
		endcase
		// Inbound translation link; sender spends a credit per message
		take_v[POOL_XLAT] = xlat_tvalid && s_q.xlat_tready;
		give_v[POOL_XLAT] = in_done && count_v[POOL_XLAT] != '0;
		s_d.in_valid = take_v[POOL_XLAT];
		if (take_v[POOL_XLAT]) begin
			s_d.in_data = xlat_tdata;
			s_d.in_src = xlat_tid;
		end
		nxt = count_v[POOL_XLAT] + CW'(take_v[POOL_XLAT]) - CW'(give_v[POOL_XLAT]);
		s_d.xlat_tready = nxt < POOL_LIMIT[POOL_XLAT];
		s_d.xlat_credit_ret = give_v[POOL_XLAT];
		// Cross-chip link: one packet in flight per slot keeps order
		give_v[POOL_MSG +: 3] = chip_credit_ret;
		s_d.msg_ack = 1'b0;
		if (s_q.chip_tvalid && chip_tready) begin
			s_d.chip_tvalid = 1'b0;
		end
		if ((!s_q.chip_tvalid || chip_tready) && msg_valid && !s_q.msg_ack
			&& msg_class != CLASS_NONE && avail_v[mp]) begin
			take_v[mp] = 1'b1;
			s_d.msg_ack = 1'b1;
			s_d.chip_tvalid = 1'b1;
			s_d.chip_tdata = msg_data;
			s_d.chip_tuser = msg_class;
			s_d.chip_tdest = s_q.chip_dest;
		end
		s_d.chip_twakeup = s_d.chip_tvalid;
		// Wake link carries no destination
		s_d.wk_ack = 1'b0;
		if (s_q.wake_tvalid && wake_tready) begin
			s_d.wake_tvalid = 1'b0;
		end
		if ((!s_q.wake_tvalid || wake_tready) && wk_valid && !s_q.wk_ack) begin
			s_d.wk_ack = 1'b1;
			s_d.wake_tvalid = 1'b1;
			s_d.wake_tdata = wk_data;
		end
		s_d.wake_twakeup = s_d.wake_tvalid;
		s_d.qactive = pwakeup || xlat_twakeup || psel;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.apb_st <= APB_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// No parity outputs exist on any stream link
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign rd_poison = s_q.rd_poison;
	assign xlat_tready = s_q.xlat_tready;
	assign xlat_credit_ret = s_q.xlat_credit_ret;
	assign in_valid = s_q.in_valid;
	assign in_data = s_q.in_data;
	assign in_src = s_q.in_src;
	assign msg_ack = s_q.msg_ack;
	assign chip_tvalid = s_q.chip_tvalid;
	assign chip_tdata = s_q.chip_tdata;
	assign chip_tdest = s_q.chip_tdest;
	assign chip_tuser = s_q.chip_tuser;
	assign chip_twakeup = s_q.chip_twakeup;
	assign wk_ack = s_q.wk_ack;
	assign wake_tvalid = s_q.wake_tvalid;
	assign wake_tdata = s_q.wake_tdata;
	assign wake_twakeup = s_q.wake_twakeup;
	assign qactive = s_q.qactive;
	assign xlat_req = s_q.xlat_req;
	assign xlat_did = s_q.xlat_did;

	default clocking dif_cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_slverr_needs_ue: assert property (pslverr |-> s_q.ue && !rd_poison)
		else $error("slave error without report enable");
	a_poison_mode: assert property (rd_poison |-> s_q.rp && !pslverr)
		else $error("read poison outside poison mode");
	a_reject_no_write: assert property (
		s_q.pready && psel && penable && pwrite && s_q.cur_err != ERR_NONE
		|=> $stable(s_q.ue) && $stable(s_q.dis) && $stable(s_q.wp) && $stable(s_q.chip_dest))
		else $error("rejected write changed a register");
	a_error_logged: assert property (
		s_q.pready && psel && penable && s_q.cur_err != ERR_NONE
		|=> s_q.err_v && s_q.err_type == $past(s_q.cur_err))
		else $error("errant access not logged");
	a_size_check: assert property (
		psel && penable && !pready && pwrite && paddr == OFF_CHIP_DEST && pstrb == 4'h3
		|=> s_q.cur_err == ERR_SIZE) else $error("partial strobe accepted");
	a_chip_dest: assert property ($rose(chip_tvalid) |-> chip_tdest == $past(s_q.chip_dest))
		else $error("chip destination not programmed value");
	a_wake_valid: assert property (chip_tvalid == chip_twakeup && wake_tvalid == wake_twakeup)
		else $error("wake line not tied to registered valid");
	a_chip_hold: assert property (
		chip_tvalid && !chip_tready |=> chip_tvalid && $stable(chip_tdata) && $stable(chip_tuser))
		else $error("packet changed before acceptance");
	a_xlat_cap: assert property (xlat_tready |-> count_v[POOL_XLAT] < POOL_LIMIT[POOL_XLAT])
		else $error("translation credits exceeded");
	a_wake_in: assert property (pwakeup |=> qactive)
		else $error("register port wake ignored");

	c_write_commit: cover property (pready && psel && penable && pwrite && s_q.cur_err == ERR_NONE);
	c_slverr: cover property (pslverr);
	c_poison_read: cover property (rd_poison);
	c_chip_send: cover property (chip_tvalid && chip_tready);
endmodule : dif_frontend

// *** hdl/dif_pkg.sv ***
// Shared constants and types for the distributor interface front end
package dif_pkg;
	localparam int AW = 8;
	localparam int DW = 32;
	localparam int CW = 5;
	localparam int DID_W = 5;
	localparam int DEST_W = 6;
	localparam int SRC_W = 5;
	localparam int NPOOL = 4;
	localparam int NDIS = 3;
	// Register offsets
	localparam logic [AW-1:0] OFF_ERR_CTRL = 8'h00;
	localparam logic [AW-1:0] OFF_FUNC_CTRL = 8'h04;
	localparam logic [AW-1:0] OFF_ERR_STAT = 8'h08;
	localparam logic [AW-1:0] OFF_ERR_ADDR = 8'h0c;
	localparam logic [AW-1:0] OFF_CHIP_DEST = 8'h10;
	localparam logic [AW-1:0] OFF_LINK_STAT = 8'h14;
	localparam logic [AW-1:0] OFF_XLAT_DID = 8'h18;
	localparam logic [AW-1:0] OFF_ISTATE = 8'h20;
	localparam logic [AW-1:0] OFF_MSG_XLAT = 8'h40;
	localparam logic [AW-1:0] UNIMP_BASE = 8'h80;
	// Field positions
	localparam int UE_BIT = 0;
	localparam int DIS_LSB = 1;
	localparam int DIS_RANGE = 0;
	localparam int DIS_UNIMP = 1;
	localparam int DIS_SIZE = 2;
	localparam int RP_BIT = 0;
	localparam int WP_BIT = 1;
	localparam int ERRV_BIT = 0;
	localparam int ETYPE_LSB = 1;
	localparam int PROT_NS_BIT = 1;
	// Build options
	localparam logic MONOLITHIC = 1'b1;
	localparam logic [2:0] REG_BYTES = 3'h4;
	localparam logic [1:0] CLASS_NONE = 2'h3;
	localparam int POOL_XLAT = 0;
	localparam int POOL_MSG = 1;
	localparam logic [CW-1:0] XLAT_CREDITS = 5'h08;
	localparam logic [CW-1:0] LOCKED_CREDIT_COUNT = 5'h02;
	localparam logic [CW-1:0] CHIP_MSG_TOKEN_COUNT = 5'h04;
	localparam logic [CW-1:0] CHIP_SOFTINT_TOKEN_COUNT = 5'h04;
	localparam logic [CW-1:0] CHIP_VIRT_SOFTINT_TOKENS = 5'h04;
	localparam logic [NPOOL-1:0][CW-1:0] POOL_LIMIT = {CHIP_VIRT_SOFTINT_TOKENS,
		CHIP_SOFTINT_TOKEN_COUNT, CHIP_MSG_TOKEN_COUNT, XLAT_CREDITS + LOCKED_CREDIT_COUNT};
	typedef enum logic [2:0] {
		ERR_NONE = 3'h0,
		ERR_RANGE = 3'h1,
		ERR_UNIMP = 3'h2,
		ERR_SIZE = 3'h3,
		ERR_POISON = 3'h4,
		ERR_ECC = 3'h5
	} dif_err_t;
	typedef enum logic [1:0] {
		APB_IDLE = 2'h1,
		APB_DONE = 2'h2
	} dif_apb_t;
endpackage : dif_pkg

// *** hdl/dif_credit_if.sv ***
// Credit pool signals between the front end and its counters
`timescale 1ns/1ps
interface dif_credit_if;
	import dif_pkg::*;
	logic take;
	logic give;
	logic [CW-1:0] limit;
	logic [CW-1:0] count;
	logic avail;
	modport owner(input take, input give, input limit, output count, output avail);
	modport user(output take, output give, output limit, input count, input avail);
endinterface : dif_credit_if

// *** hdl/dif_credit.sv ***
// Outstanding-transfer counter for one credit pool
`timescale 1ns/1ps
module dif_credit (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Pool
	dif_credit_if.owner cr
);
	import dif_pkg::*;
	typedef struct packed {
		logic [CW-1:0] count;
	} dif_cred_st_t;
	dif_cred_st_t s_q;
	dif_cred_st_t s_d;

	always_comb begin
		s_d = s_q;
		if (cr.take && !cr.give) begin
			s_d.count = s_q.count + 5'h01;
		end else if (cr.give && !cr.take && s_q.count != '0) begin
			s_d.count = s_q.count - 5'h01;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign cr.count = s_q.count;
	assign cr.avail = s_q.count < cr.limit;

	a_count_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
		s_q.count <= cr.limit) else $error("credit count above limit");
	a_take_counts: assert property (@(posedge core_clk) disable iff (!rst_n)
		cr.take && !cr.give |=> s_q.count == $past(s_q.count) + 5'h01)
		else $error("credit take not counted");
endmodule : dif_credit

// *** verif/dif_link_partner.sv ***
// Far-side model of the cross-chip and wake stream links
`timescale 1ns/1ps
module dif_link_partner (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Test controls
	input wire logic slow,
	input wire logic ret_en,
	// Cross-chip link
	input wire logic chip_tvalid,
	input wire logic [63:0] chip_tdata,
	input wire logic [dif_pkg::DEST_W-1:0] chip_tdest,
	input wire logic [1:0] chip_tuser,
	input wire logic chip_twakeup,
	output logic chip_tready,
	output logic [2:0] chip_credit_ret,
	// Wake link
	input wire logic wake_tvalid,
	input wire logic [15:0] wake_tdata,
	input wire logic wake_twakeup,
	output logic wake_tready,
	// Observations
	output int beats,
	output logic [63:0] last_data,
	output logic [dif_pkg::DEST_W-1:0] last_dest,
	output logic [1:0] last_class,
	output logic [15:0] wake_last
);
	import dif_pkg::*;
	logic [2:0][3:0] owed_q;
	logic tgl_q;
	// Slow mode stalls every other cycle
	assign chip_tready = !slow || tgl_q;
	assign wake_tready = !slow || tgl_q;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			owed_q <= '0;
			tgl_q <= 1'b0;
			chip_credit_ret <= 3'h0;
			beats <= 0;
			last_data <= 64'h0;
			last_dest <= '0;
			last_class <= 2'h0;
			wake_last <= 16'h0;
		end else begin
			tgl_q <= ~tgl_q;
			// Tokens go back only for beats already consumed
			for (int k = 0; k < 3; k++) begin
				chip_credit_ret[k] <= ret_en && owed_q[k] != 4'h0;
				owed_q[k] <= owed_q[k] + 4'(chip_tvalid && chip_tready && chip_tuser == 2'(k))
					- 4'(ret_en && owed_q[k] != 4'h0);
			end
			// Beats taken whole and in arrival order
			if (chip_tvalid && chip_tready) begin
				beats <= beats + 1;
				last_data <= chip_tdata;
				last_dest <= chip_tdest;
				last_class <= chip_tuser;
			end
			if (wake_tvalid && wake_tready) begin
				wake_last <= wake_tdata;
			end
		end
	end
endmodule : dif_link_partner

// *** verif/dif_frontend_test.sv ***
// Self-checking bench for the distributor interface front end
`timescale 1ns/1ps
module dif_frontend_test;
	import dif_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wr_poison = 1'b0, pwakeup = 1'b0;
	logic [AW-1:0] paddr = '0;
	logic [DW-1:0] pwdata = '0, istate_data = 32'ha5a5_0001, prdata;
	logic [3:0] pstrb = 4'hf;
	logic [2:0] pprot = 3'h0;
	logic [DID_W-1:0] pwuser = 5'h13, xlat_did;
	logic pready, pslverr, rd_poison, istate_ecc_err = 1'b0;
	logic xlat_tvalid = 1'b0, xlat_twakeup = 1'b0, in_done = 1'b0, xlat_tready, xlat_credit_ret;
	logic [15:0] xlat_tdata = 16'hbeef, in_data, wk_data = 16'h5a5a, wake_tdata;
	logic [SRC_W-1:0] xlat_tid = 5'h07, in_src;
	logic in_valid, msg_valid = 1'b0, msg_ack, chip_tvalid, chip_twakeup, chip_tready;
	logic [1:0] msg_class = 2'h0, chip_tuser, p_class;
	logic [63:0] msg_data = 64'h0123_4567_89ab_cdef, chip_tdata, p_data;
	logic [DEST_W-1:0] chip_tdest, p_dest;
	logic [2:0] chip_credit_ret;
	logic wk_valid = 1'b0, wk_ack, wake_tvalid, wake_twakeup, wake_tready;
	logic qactive, xlat_req, slow = 1'b1, ret_en = 1'b0;
	logic [15:0] p_wake;
	int p_beats, mismatches = 0, n_tests = 0, cyc = 0, n_in = 0, n_ret = 0, n_ack = 0, n_req = 0;
	int n_wkx = 0;

	dif_frontend uut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot),
		.pwuser(pwuser), .wr_poison(wr_poison), .pwakeup(pwakeup), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rd_poison(rd_poison), .istate_data(istate_data),
		.istate_ecc_err(istate_ecc_err), .xlat_tvalid(xlat_tvalid), .xlat_tdata(xlat_tdata),
		.xlat_tid(xlat_tid), .xlat_twakeup(xlat_twakeup), .xlat_tready(xlat_tready),
		.xlat_credit_ret(xlat_credit_ret), .in_valid(in_valid), .in_data(in_data),
		.in_src(in_src), .in_done(in_done), .msg_valid(msg_valid), .msg_class(msg_class),
		.msg_data(msg_data), .msg_ack(msg_ack), .chip_tvalid(chip_tvalid),
		.chip_tdata(chip_tdata), .chip_tdest(chip_tdest), .chip_tuser(chip_tuser),
		.chip_twakeup(chip_twakeup), .chip_tready(chip_tready),
		.chip_credit_ret(chip_credit_ret), .wk_valid(wk_valid), .wk_data(wk_data),
		.wk_ack(wk_ack), .wake_tvalid(wake_tvalid), .wake_tdata(wake_tdata),
		.wake_twakeup(wake_twakeup), .wake_tready(wake_tready), .qactive(qactive),
		.xlat_req(xlat_req), .xlat_did(xlat_did));

	dif_link_partner far (.core_clk(core_clk), .rst_n(rst_n), .slow(slow), .ret_en(ret_en),
		.chip_tvalid(chip_tvalid), .chip_tdata(chip_tdata), .chip_tdest(chip_tdest),
		.chip_tuser(chip_tuser), .chip_twakeup(chip_twakeup), .chip_tready(chip_tready),
		.chip_credit_ret(chip_credit_ret), .wake_tvalid(wake_tvalid), .wake_tdata(wake_tdata),
		.wake_twakeup(wake_twakeup), .wake_tready(wake_tready), .beats(p_beats),
		.last_data(p_data), .last_dest(p_dest), .last_class(p_class), .wake_last(p_wake));

	always #20 core_clk = ~core_clk;

	// Wake lines are registered copies so glitches never reach them
	always @(posedge core_clk) begin
		pwakeup <= psel;
		xlat_twakeup <= xlat_tvalid;
		n_in += int'(in_valid === 1'b1);
		n_ret += int'(xlat_credit_ret === 1'b1);
		n_ack += int'(msg_ack === 1'b1);
		n_req += int'(xlat_req === 1'b1);
		n_wkx += int'(chip_twakeup !== chip_tvalid || wake_twakeup !== wake_tvalid);
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			final_report();
		end
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report

	// One APB transfer; waits for pready, then checks it came two cycles after penable
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] rd, output logic er, output logic po);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		// Single beat, no burst, atomic or snoop attributes
		pstrb <= s;
		@(posedge core_clk);
		penable <= 1'b1;
		// Only pready or the bench timeout ends this wait
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1);
		chk(64'(n), 64'h2);
		chk(64'(qactive), 64'h1);
		rd = prdata;
		er = pslverr;
		po = rd_poison;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic ee);
		logic [31:0] rd;
		logic er, po;
		apb(1'b1, a, d, s, rd, er, po);
		chk(64'(er), 64'(ee));
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, input logic [31:0] ed, input logic ee,
		input logic ep);
		logic [31:0] rd;
		logic er, po;
		apb(1'b0, a, 32'h0, 4'h0, rd, er, po);
		chk(64'(rd), 64'(ed));
		chk(64'(er), 64'(ee));
		chk(64'(po), 64'(ep));
	endtask : reg_rd

	initial begin
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		reg_rd(OFF_ERR_CTRL, 32'h0, 1'b0, 1'b0);
		reg_rd(OFF_FUNC_CTRL, 32'h0, 1'b0, 1'b0);
		reg_wr(OFF_CHIP_DEST, 32'h2a, 4'hf, 1'b0);
		reg_rd(OFF_CHIP_DEST, 32'h2a, 1'b0, 1'b0);
		reg_rd(8'h30, 32'h0, 1'b0, 1'b0);
		reg_rd(OFF_ERR_STAT, 32'h3, 1'b0, 1'b0);
		reg_wr(OFF_ERR_CTRL, 32'h1, 4'hf, 1'b0);
		reg_rd(8'h30, 32'h0, 1'b1, 1'b0);
		reg_rd(8'h84, 32'h0, 1'b1, 1'b0);
		reg_rd(OFF_ERR_STAT, 32'h5, 1'b0, 1'b0);
		reg_wr(OFF_ERR_CTRL, 32'h3, 4'hf, 1'b0);
		reg_rd(8'h30, 32'h0, 1'b0, 1'b0);
		reg_wr(OFF_CHIP_DEST, 32'hff, 4'h3, 1'b1);
		reg_wr(OFF_CHIP_DEST, 32'hff, 4'h5, 1'b1);
		reg_rd(OFF_CHIP_DEST, 32'h2a, 1'b0, 1'b0);
		pprot <= 3'h2;
		reg_rd(OFF_ERR_CTRL, 32'h0, 1'b0, 1'b0);
		reg_wr(OFF_ERR_CTRL, 32'h0, 4'hf, 1'b0);
		pprot <= 3'h0;
		reg_rd(OFF_ERR_CTRL, 32'h3, 1'b0, 1'b0);
		wr_poison <= 1'b1;
		reg_wr(OFF_CHIP_DEST, 32'h15, 4'hf, 1'b0);
		reg_wr(OFF_FUNC_CTRL, 32'h2, 4'hf, 1'b0);
		wr_poison <= 1'b0;
		reg_wr(OFF_FUNC_CTRL, 32'h2, 4'hf, 1'b0);
		wr_poison <= 1'b1;
		reg_wr(OFF_CHIP_DEST, 32'h33, 4'hf, 1'b1);
		wr_poison <= 1'b0;
		reg_rd(OFF_CHIP_DEST, 32'h15, 1'b0, 1'b0);
		istate_ecc_err <= 1'b1;
		reg_rd(OFF_ISTATE, 32'ha5a5_0001, 1'b1, 1'b0);
		reg_wr(OFF_FUNC_CTRL, 32'h3, 4'hf, 1'b0);
		reg_rd(OFF_ISTATE, 32'ha5a5_0001, 1'b0, 1'b1);
		reg_wr(OFF_FUNC_CTRL, 32'h0, 4'hf, 1'b0);
		reg_wr(OFF_ERR_CTRL, 32'h0, 4'hf, 1'b0);
		reg_rd(OFF_ISTATE, 32'ha5a5_0001, 1'b0, 1'b0);
		istate_ecc_err <= 1'b0;
		reg_wr(OFF_MSG_XLAT, 32'h9, 4'hf, 1'b0);
		chk(64'(xlat_did), 64'h13);
		// Let the pulse counter see the edge after commit
		@(posedge core_clk);
		chk(64'(n_req), 64'h1);
		// Inbound link: hold valid without consuming anything
		xlat_tvalid <= 1'b1;
		repeat (20) @(posedge core_clk);
		xlat_tvalid <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk(64'(n_in), 64'(POOL_LIMIT[POOL_XLAT]));
		chk(64'(xlat_tready), 64'h0);
		chk(64'({in_src, in_data}), {43'h0, 5'h07, 16'hbeef});
		in_done <= 1'b1;
		repeat (2) @(posedge core_clk);
		in_done <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk(64'(n_ret), 64'h2);
		chk(64'(xlat_tready), 64'h1);
		// Cross-chip link: tokens held back by the far side
		for (int k = 0; k < 4; k++) begin
			n_ack = 0;
			msg_class <= 2'(k);
			msg_valid <= 1'b1;
			repeat (30) @(posedge core_clk);
			msg_valid <= 1'b0;
			repeat (3) @(posedge core_clk);
			chk(64'(n_ack), (k == 3) ? 64'h0 : 64'(POOL_LIMIT[k + 1]));
		end
		chk(64'(p_beats), 64'h0c);
		chk(p_data, msg_data);
		chk(64'({p_dest, p_class}), 64'({6'h15, 2'h2}));
		ret_en <= 1'b1;
		slow <= 1'b0;
		repeat (10) @(posedge core_clk);
		n_ack = 0;
		msg_class <= 2'h0;
		msg_valid <= 1'b1;
		repeat (30) @(posedge core_clk);
		msg_valid <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk(64'(n_ack > 4), 64'h1);
		wk_valid <= 1'b1;
		do @(posedge core_clk); while (wk_ack !== 1'b1 && cyc < 4990);
		wk_valid <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk(64'(p_wake), 64'h5a5a);
		chk(64'(n_wkx), 64'h0);
		final_report();
	end
endmodule : dif_frontend_test
